// ### banked_data_memory_decoder.sv
// What this block does
// [R01] offsets 0Ch-1Fh of every bank decode to peripheral control registers
// [R02] offsets 20h to 6Fh decode to general ram only in ram banks
// [R03] offsets 70h to 7Fh reach one common ram shared by all banks
// [R04] indirect pointer accesses see all general ram as one linear range
// [R05] no bank exposes more than 80 bytes of general ram
// [R06] 7-bit offset, 12 core registers first, address is bank then offset
`timescale 1ns/100ps
module banked_data_memory_decoder
    import bank_map_pkg::*;
(
    input  wire logic                 sys_clk,
    input  wire logic                 rst_n,
    input  wire logic                 req_valid,
    input  wire logic                 req_indirect,
    input  wire logic [BANK_W-1:0]    req_bank,
    input  wire logic [OFF_W-1:0]     req_offset,
    input  wire logic [LIN_W-1:0]     req_linear,
    output logic                      rsp_valid,
    output region_t                   rsp_region,
    output logic      [ADDR_W-1:0]    rsp_addr,
    output logic      [RAM_IDX_W-1:0] rsp_ram_index,
    output logic      [COM_IDX_W-1:0] rsp_common_index
);

    typedef struct packed {
        logic                 valid;
        region_t              region;
        logic [ADDR_W-1:0]    addr;
        logic [RAM_IDX_W-1:0] ram_index;
        logic [COM_IDX_W-1:0] common_index;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic [BANK_W-1:0]    lin_bank;
    logic [OFF_W-1:0]     lin_offset;
    logic [RAM_IDX_W-1:0] lin_index;
    logic                 lin_hit;

    function automatic region_t decode_region(
        input logic [BANK_W-1:0] bank,
        input logic [OFF_W-1:0]  off
    );
        region_t r;
        if (off <= CORE_LAST) begin
            r = REGION_CORE;                                  // R06
        end else if (off <= PERIPH_LAST) begin
            r = REGION_PERIPH;                                // R01
        end else if (off <= GRAM_LAST) begin
            // banks without ram leave the window unimplemented
            r = (bank <= GRAM_BANK_LAST) ? REGION_GRAM : REGION_NONE; // R02
        end else begin
            r = REGION_COMMON;                                // R03
        end
        return r;
    endfunction

    function automatic logic [RAM_IDX_W-1:0] gram_index(
        input logic [BANK_W-1:0] bank,
        input logic [OFF_W-1:0]  off
    );
        logic [RAM_IDX_W-1:0] sub;
        sub = RAM_IDX_W'(off - GRAM_FIRST);
        return RAM_IDX_W'(32'(bank) * 32'(GRAM_BYTES)) + sub;  // R05
    endfunction

    linear_ram_translator u_lin (
        .lin_addr   (req_linear),
        .lin_bank   (lin_bank),
        .lin_offset (lin_offset),
        .lin_index  (lin_index),
        .lin_hit    (lin_hit)
    );

    always_comb begin
        st_nxt       = st_r;
        st_nxt.valid = req_valid;
        if (req_valid) begin
            if (req_indirect) begin
                // pointer accesses bypass the bank select entirely
                st_nxt.common_index = '0;
                if (lin_hit) begin
                    st_nxt.region    = REGION_GRAM;           // R04
                    st_nxt.addr      = {lin_bank, lin_offset}; // R04
                    st_nxt.ram_index = lin_index;
                end else begin
                    st_nxt.region    = REGION_NONE;
                    st_nxt.addr      = '0;
                    st_nxt.ram_index = '0;
                end
            end else begin
                st_nxt.region = decode_region(req_bank, req_offset);
                st_nxt.addr   = {req_bank, req_offset};       // R06
                st_nxt.ram_index = '0;
                st_nxt.common_index = '0;
                if (st_nxt.region == REGION_GRAM) begin
                    st_nxt.ram_index = gram_index(req_bank, req_offset);
                end
                if (st_nxt.region == REGION_COMMON) begin
                    // bank bits dropped: one physical block for all
                    st_nxt.common_index = req_offset[COM_IDX_W-1:0]; // R03
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '{valid: 1'b0, region: REGION_NONE, addr: '0,
                      ram_index: '0, common_index: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rsp_valid        = st_r.valid;
    assign rsp_region       = st_r.region;
    assign rsp_addr         = st_r.addr;
    assign rsp_ram_index    = st_r.ram_index;
    assign rsp_common_index = st_r.common_index;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence seq_direct;
        req_valid && !req_indirect;
    endsequence

    sequence seq_periph_req;
        seq_direct ##0 (req_offset >= PERIPH_FIRST) &&
                       (req_offset <= PERIPH_LAST);
    endsequence

    sequence seq_gram_req;
        seq_direct ##0 (req_offset >= GRAM_FIRST) &&
                       (req_offset <= GRAM_LAST);
    endsequence

    sequence seq_linear_hit;
        req_valid && req_indirect && (req_linear >= LIN_BASE) &&
        ((req_linear - LIN_BASE) < LIN_W'(GRAM_TOTAL));
    endsequence

    sequence seq_linear_over;
        req_valid && req_indirect && (req_linear >= LIN_BASE) &&
        ((req_linear - LIN_BASE) >= LIN_W'(GRAM_TOTAL));
    endsequence

    AST_PERIPH: assert property ( // R01
        seq_periph_req |=> rsp_valid && rsp_region == REGION_PERIPH)
        else $error("peripheral offset not decoded as peripheral");

    AST_GRAM_BANK: assert property ( // R02
        seq_gram_req |=> (rsp_region == REGION_GRAM) ==
                         ($past(req_bank) <= GRAM_BANK_LAST))
        else $error("general ram decode disagrees with bank");

    AST_COMMON: assert property ( // R03
        seq_direct ##0 (req_offset >= COMMON_FIRST) |=>
            rsp_region == REGION_COMMON &&
            rsp_common_index == $past(req_offset[COM_IDX_W-1:0]))
        else $error("common ram not shared across banks");

    AST_LINEAR: assert property ( // R04
        seq_linear_hit |=> rsp_region == REGION_GRAM &&
            rsp_ram_index == RAM_IDX_W'($past(req_linear) - LIN_BASE))
        else $error("linear access index wrong");

    AST_LINEAR_MISS: assert property ( // R04
        req_valid && req_indirect && (req_linear < LIN_BASE) |=>
            rsp_region == REGION_NONE)
        else $error("linear access below window decoded");

    AST_GRAM_LIMIT: assert property ( // R05
        rsp_region == REGION_GRAM |->
            rsp_addr[OFF_W-1:0] >= GRAM_FIRST &&
            rsp_addr[OFF_W-1:0] <= GRAM_LAST &&
            rsp_addr[ADDR_W-1:OFF_W] <= GRAM_BANK_LAST &&
            rsp_ram_index < GRAM_TOTAL)
        else $error("general ram beyond 80 bytes per bank");

    AST_CORE_ADDR: assert property ( // R06
        seq_direct ##0 (req_offset <= CORE_LAST) |=>
            rsp_region == REGION_CORE &&
            rsp_addr == {$past(req_bank), $past(req_offset)})
        else $error("core register decode or address wrong");

    AST_VALID: assert property ( // R06
        rsp_valid == $past(req_valid))
        else $error("answer not one cycle after request");

    AST_LINEAR_OVER: assert property ( // R04
        seq_linear_over |=> rsp_valid && rsp_region == REGION_NONE &&
            rsp_addr == '0 && rsp_ram_index == '0)
        else $error("linear access above window decoded");

    AST_LINEAR_ADDR: assert property ( // R04
        seq_linear_hit |=> 32'(rsp_ram_index) ==
            32'(rsp_addr[ADDR_W-1:OFF_W]) * 32'(GRAM_BYTES) +
            32'(rsp_addr[OFF_W-1:0]) - 32'(GRAM_FIRST))
        else $error("linear bank and offset disagree with index");

    AST_PERIPH_ADDR: assert property ( // R01
        seq_periph_req |=>
            rsp_addr == {$past(req_bank), $past(req_offset)} &&
            rsp_ram_index == '0 && rsp_common_index == '0)
        else $error("peripheral access address wrong");

    AST_GRAM_INDEX: assert property ( // R05
        seq_gram_req ##0 (req_bank <= GRAM_BANK_LAST) |=>
            32'(rsp_ram_index) == 32'($past(req_bank)) * 32'(GRAM_BYTES) +
            32'($past(req_offset)) - 32'(GRAM_FIRST))
        else $error("general ram index wrong");

    AST_NO_RAM_BANK: assert property ( // R02
        seq_gram_req ##0 (req_bank > GRAM_BANK_LAST) |=>
            rsp_region == REGION_NONE && rsp_ram_index == '0)
        else $error("general ram decoded in bank without ram");

    AST_HOLD: assert property ( // R06
        !req_valid |=> !rsp_valid && $stable(rsp_region) &&
            $stable(rsp_addr) && $stable(rsp_common_index))
        else $error("answer changed without a request");

endmodule

// ### bank_map_pkg.sv
package bank_map_pkg;

    localparam int BANK_W    = 5;
    localparam int OFF_W     = 7;
    localparam int ADDR_W    = BANK_W + OFF_W;
    localparam int LIN_W     = 16;
    localparam int RAM_IDX_W = 11;
    localparam int COM_IDX_W = 4;

    // bank offset boundaries
    localparam logic [OFF_W-1:0] CORE_LAST    = 7'h0b;
    localparam logic [OFF_W-1:0] PERIPH_FIRST = 7'h0c;
    localparam logic [OFF_W-1:0] PERIPH_LAST  = 7'h1f;
    localparam logic [OFF_W-1:0] GRAM_FIRST   = 7'h20;
    localparam logic [OFF_W-1:0] GRAM_LAST    = 7'h6f;
    localparam logic [OFF_W-1:0] COMMON_FIRST = 7'h70;

    // sizes of the banked regions
    localparam logic [RAM_IDX_W-1:0] GRAM_BYTES   = 11'h050;
    localparam logic [RAM_IDX_W-1:0] COMMON_BYTES = 11'h010;

    // banks 0 up to this one carry general ram
    localparam logic [BANK_W-1:0] GRAM_BANK_LAST = 5'h17;
    localparam logic [RAM_IDX_W-1:0] GRAM_TOTAL =
        RAM_IDX_W'((32'(GRAM_BANK_LAST) + 32'h1) * 32'(GRAM_BYTES));

    // start of the linear window seen through the indirect pointers
    localparam logic [LIN_W-1:0] LIN_BASE = 16'h4000;

    typedef enum logic [2:0] {
        REGION_NONE,
        REGION_CORE,
        REGION_PERIPH,
        REGION_GRAM,
        REGION_COMMON
    } region_t;

endpackage

// ### linear_ram_translator.sv
`timescale 1ns/100ps
module linear_ram_translator
    import bank_map_pkg::*;
(
    input  wire logic [LIN_W-1:0]     lin_addr,
    output logic      [BANK_W-1:0]    lin_bank,
    output logic      [OFF_W-1:0]     lin_offset,
    output logic      [RAM_IDX_W-1:0] lin_index,
    output logic                      lin_hit
);

    logic [LIN_W-1:0] rel;

    // general ram of all banks laid end to end, 80 bytes per bank
    always_comb begin
        rel        = lin_addr - LIN_BASE;
        lin_hit    = (lin_addr >= LIN_BASE) &&
                     (rel < LIN_W'(GRAM_TOTAL));              // R04
        lin_index  = rel[RAM_IDX_W-1:0];
        lin_bank   = BANK_W'(lin_index / GRAM_BYTES);         // R04
        lin_offset = OFF_W'(lin_index % GRAM_BYTES) + GRAM_FIRST; // R05
    end

endmodule

// ### core_access_model.sv
`timescale 1ns/100ps
module core_access_model
    import bank_map_pkg::*;
(
    input  wire logic              sys_clk,
    output logic                   req_valid,
    output logic                   req_indirect,
    output logic      [BANK_W-1:0] req_bank,
    output logic      [OFF_W-1:0]  req_offset,
    output logic      [LIN_W-1:0]  req_linear
);
    initial begin
        req_valid    = 1'b0;
        req_indirect = 1'b0;
        req_bank     = '0;
        req_offset   = '0;
        req_linear   = '0;
    end

    // entered just after a rising edge; held until the taking edge
    task automatic issue(input logic ind, input logic [BANK_W-1:0] b,
                         input logic [OFF_W-1:0] o,
                         input logic [LIN_W-1:0] lin);
        req_valid    = 1'b1;
        req_indirect = ind;
        req_bank     = b;
        req_offset   = o;
        req_linear   = lin;
        @(posedge sys_clk);
        #1;
    endtask

    // released fields flip so a stale address can never look valid
    task automatic idle();
        req_valid    = 1'b0;
        req_indirect = ~req_indirect;
        req_bank     = ~req_bank;
        req_offset   = ~req_offset;
        req_linear   = ~req_linear;
    endtask
endmodule

// ### banked_data_memory_decoder_test.sv
`timescale 1ns/100ps
module banked_data_memory_decoder_test
    import bank_map_pkg::*;
;
    logic                 sys_clk;
    logic                 rst_n;
    logic                 req_valid;
    logic                 req_indirect;
    logic [BANK_W-1:0]    req_bank;
    logic [OFF_W-1:0]     req_offset;
    logic [LIN_W-1:0]     req_linear;
    logic                 rsp_valid;
    region_t              rsp_region;
    logic [ADDR_W-1:0]    rsp_addr;
    logic [RAM_IDX_W-1:0] rsp_ram_index;
    logic [COM_IDX_W-1:0] rsp_common_index;
    int                   fail_count;
    int                   checks;

    core_access_model core (.sys_clk(sys_clk), .req_valid(req_valid),
        .req_indirect(req_indirect), .req_bank(req_bank),
        .req_offset(req_offset), .req_linear(req_linear));

    banked_data_memory_decoder uut (.sys_clk(sys_clk), .rst_n(rst_n),
        .req_valid(req_valid), .req_indirect(req_indirect),
        .req_bank(req_bank), .req_offset(req_offset),
        .req_linear(req_linear), .rsp_valid(rsp_valid),
        .rsp_region(rsp_region), .rsp_addr(rsp_addr),
        .rsp_ram_index(rsp_ram_index),
        .rsp_common_index(rsp_common_index));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one request, answer judged in the cycle after the taking edge
    task automatic access(input logic ind, input logic [BANK_W-1:0] b,
                          input logic [OFF_W-1:0] o,
                          input logic [LIN_W-1:0] lin, input region_t er,
                          input logic [BANK_W-1:0] eb,
                          input logic [OFF_W-1:0] eo);
        logic [ADDR_W-1:0] ea;
        ea = (ind && er == REGION_NONE) ? '0 : {eb, eo};
        core.issue(ind, b, o, lin);
        cmp(16'(rsp_valid), 16'h0001);
        cmp(16'(rsp_region), 16'(er));
        cmp(16'(rsp_addr), 16'(ea));
        cmp(16'(rsp_ram_index), (er == REGION_GRAM) ?
            16'(32'(eb) * 32'd80 + 32'(eo) - 32'h20) : 16'h0000);
        cmp(16'(rsp_common_index),
            (er == REGION_COMMON) ? 16'(eo[3:0]) : 16'h0000);
    endtask

    task automatic bank_edges(input logic [BANK_W-1:0] b);
        access(0, b, 7'h0b, '0, REGION_CORE, b, 7'h0b);
        access(0, b, 7'h0c, '0, REGION_PERIPH, b, 7'h0c);
        access(0, b, 7'h1f, '0, REGION_PERIPH, b, 7'h1f);
        access(0, b, 7'h70, '0, REGION_COMMON, b, 7'h70);
        access(0, b, 7'h7f, '0, REGION_COMMON, b, 7'h7f);
    endtask

    task automatic test_ram_limit();
        access(0, 5'h00, 7'h20, '0, REGION_GRAM, 5'h00, 7'h20);
        access(0, 5'h02, 7'h25, '0, REGION_GRAM, 5'h02, 7'h25);
        access(0, 5'h17, 7'h6f, '0, REGION_GRAM, 5'h17, 7'h6f);
        access(0, 5'h18, 7'h20, '0, REGION_NONE, 5'h18, 7'h20);
        access(0, 5'h1f, 7'h6f, '0, REGION_NONE, 5'h1f, 7'h6f);
    endtask

    task automatic test_linear();
        access(1, '0, '0, 16'h4050, REGION_GRAM, 5'h01, 7'h20);
        access(1, '0, '0, 16'h4000, REGION_GRAM, 5'h00, 7'h20);
        access(1, '0, '0, 16'h477f, REGION_GRAM, 5'h17, 7'h6f);
        access(1, '0, '0, 16'h4780, REGION_NONE, '0, '0);
        access(1, '0, '0, 16'h3fff, REGION_NONE, '0, '0);
    endtask

    task automatic test_hold();
        access(0, 5'h09, 7'h73, '0, REGION_COMMON, 5'h09, 7'h73);
        core.idle();
        @(posedge sys_clk);
        #1;
        cmp(16'(rsp_valid), 16'h0000);
        cmp(16'(rsp_region), 16'(REGION_COMMON));
        cmp(16'(rsp_common_index), 16'h0003);
        cmp(16'(rsp_addr), 16'({5'h09, 7'h73}));
    endtask

    initial begin
        repeat (2000) @(posedge sys_clk);
        fail_count++;
        summarize();
    end

    initial begin
        fail_count = 0;
        checks = 0;
        rst_n = 1'b0;
        repeat (6) @(posedge sys_clk);
        #1;
        cmp(16'(rsp_valid), 16'h0000);
        cmp(16'(rsp_region), 16'(REGION_NONE));
        cmp(16'(rsp_addr), 16'h0000);
        rst_n = 1'b1;
        @(posedge sys_clk);
        #1;
        bank_edges(5'h00);
        bank_edges(5'h1f);
        test_ram_limit();
        test_linear();
        test_hold();
        summarize();
    end
endmodule
